// file: rtl/tlm_cfg.svh
`ifndef TLM_CFG_SVH
`define TLM_CFG_SVH

// register byte addresses (index times four)
`define TLM_IDX_CTRL 0
`define TLM_IDX_BSTAT 1
`define TLM_IDX_DSTAT 17
`define TLM_IDX_OPS 18
`define TLM_ADDR_CTRL 12'(4 * `TLM_IDX_CTRL)
`define TLM_ADDR_BSTAT 12'(4 * `TLM_IDX_BSTAT)
`define TLM_ADDR_DSTAT 12'(4 * `TLM_IDX_DSTAT)
`define TLM_ADDR_OPS 12'(4 * `TLM_IDX_OPS)

// field positions
`define TLM_CTRL_FDX 8
`define TLM_BSTAT_LINK 2
`define TLM_DSTAT_LINK 0
`define TLM_OPS_SQ_INH 0

// reset values
`define TLM_RST_FDX 1'h0
`define TLM_RST_SQ_INH 1'h0
`define TLM_RST_WORD 32'h0000_0000

// timing
`define TLM_CLK_KHZ 40000
`define TLM_NLP_MS 16
`define TLM_LOSS_MS 82
`define TLM_MII_KHZ 2500
`define TLM_MII_HALF (`TLM_CLK_KHZ / `TLM_MII_KHZ / 2)
`define TLM_NLP_NEED 8
`define TLM_LOCK_BITS 3

`endif

// file: rtl/tlm_pkg.sv
package tlm_pkg;

  typedef enum logic [2:0] {
    TLM_INVALID = 3'h1,
    TLM_WAIT_END = 3'h2,
    TLM_VALID = 3'h4
  } tlm_link_e;

  typedef logic [21:0] tlm_cnt_t;

endpackage : tlm_pkg

// file: rtl/tlm_pulse_timer.sv
module tlm_pulse_timer
  import tlm_pkg::*;
#(
  parameter int unsigned PERIOD = 16
) (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic restart, // clear count
  input wire logic run, // count enable
  output logic tick // one-cycle pulse each period
);

  typedef struct packed {
    tlm_cnt_t cnt;
    logic tick;
  } tlm_tmr_s;

  localparam tlm_cnt_t LAST = tlm_cnt_t'(PERIOD - 1);

  tlm_tmr_s s_q;
  tlm_tmr_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart) begin
      s_d.cnt = '0;
    end else if (run) begin
      if (s_q.cnt == LAST) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + tlm_cnt_t'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : tlm_pulse_timer

// file: rtl/tlm_link_monitor.sv
// How it works
// - lock recovered clock from preamble while receiving
// - send link pulse every 16 ms idle
// - link pulses continue during reception
// - link pulses never cause collision indication
// - link bit readable in two status registers
// - link bit latches low on any drop
// - more than seven pulses make link valid
// - inhibit set: any valid data qualifies
// - inhibit clear: data needs trailing idle marker
// - pulses or qualifying data keep link valid
// - silence beyond 82 ms makes link invalid
// - valid data needs three locked bit times
// - invalid link waits for packet end
// - becoming valid does not set latched bit
// - append idle marker after each transmit
// - half duplex: carrier on transmit or receive
// - full duplex: carrier only on receive
// - interface clock runs at 2.5 MHz
`include "tlm_cfg.svh"
module tlm_link_monitor
  import tlm_pkg::*;
#(
  parameter int unsigned NLP_CYCLES = `TLM_NLP_MS * `TLM_CLK_KHZ,
  parameter int unsigned LOSS_CYCLES = `TLM_LOSS_MS * `TLM_CLK_KHZ
) (
  input wire logic clk, // 40 MHz system clock
  input wire logic rst, // sync reset, high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire logic rxActive, // receive energy present
  input wire logic rxPreamble, // pulse, preamble seen
  input wire logic rxPllLock, // receive loop holds lock
  input wire logic rxBitStrobe, // pulse per recovered bit
  input wire logic rxNlp, // pulse, valid link pulse received
  input wire logic rxIdleMarker, // pulse, valid idle marker received
  input wire logic txEn, // mac transmit enable
  output logic rxClkRecovered, // mac receive clock from recovery loop
  output logic normalLinkPulse, // pulse, emit link pulse on line
  output logic txIdleMarker, // pulse, append idle marker
  output logic carrierSenseOut, // carrier sense to mac
  output logic miiClk, // 2.5 MHz interface clock
  output logic linkValid // current link state
);

  typedef struct packed {
    tlm_link_e state;
    logic [3:0] nlpCnt;
    logic [1:0] bitCnt;
    logic dataOk;
    logic idleSeen;
    logic rxActPrev;
    logic recover;
    logic linkLatch;
    logic sqInh;
    logic fdx;
    logic carrier_sense_out;
    logic txEnPrev;
    logic idleMark;
    logic [2:0] miiDiv;
    logic miiClk;
    logic [31:0] prdata;
    logic pslverr;
  } tlm_mon_s;

  tlm_mon_s s_q;
  tlm_mon_s s_d;

  logic nlpTick;
  logic lossTick;
  logic setup;
  logic access;
  logic readLink;
  logic pktEnd;
  logic qualified;
  logic lossRestart;

  function automatic logic isMapped(input logic [11:0] a);
    isMapped = (a == `TLM_ADDR_CTRL) || (a == `TLM_ADDR_BSTAT) ||
               (a == `TLM_ADDR_DSTAT) || (a == `TLM_ADDR_OPS);
  endfunction : isMapped

  function automatic logic isLinkReg(input logic [11:0] a);
    isLinkReg = (a == `TLM_ADDR_BSTAT) || (a == `TLM_ADDR_DSTAT);
  endfunction : isLinkReg

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign readLink = access && !pwrite && isLinkReg(paddr);
  assign pktEnd = s_q.rxActPrev && !rxActive;
  // idle marker may arrive in the very cycle that energy drops
  assign qualified = pktEnd && s_q.dataOk &&
                     (s_q.sqInh || s_q.idleSeen || rxIdleMarker);
  assign lossRestart = (s_q.state != TLM_VALID) || rxNlp || qualified;

  // link pulses run off txEn only, so reception never stops them
  tlm_pulse_timer #(
    .PERIOD(NLP_CYCLES)
  ) u_nlp (
    .clk(clk),
    .rst(rst),
    .restart(txEn),
    .run(1'b1),
    .tick(nlpTick)
  );

  // held while a valid packet is in progress
  tlm_pulse_timer #(
    .PERIOD(LOSS_CYCLES)
  ) u_loss (
    .clk(clk),
    .rst(rst),
    .restart(lossRestart),
    .run(!s_q.dataOk),
    .tick(lossTick)
  );

  always_comb begin
    s_d = s_q;
    s_d.rxActPrev = rxActive;
    s_d.txEnPrev = txEn;
    s_d.idleMark = s_q.txEnPrev && !txEn;
    // no collision path exists from the pulse generator
    s_d.carrier_sense_out = rxActive || (!s_q.fdx && txEn);

    if (s_q.miiDiv == 3'(`TLM_MII_HALF - 1)) begin
      s_d.miiDiv = 3'h0;
      s_d.miiClk = !s_q.miiClk;
    end else begin
      s_d.miiDiv = s_q.miiDiv + 3'h1;
    end

    if (!rxActive) begin
      s_d.recover = 1'b0;
      s_d.bitCnt = 2'h0;
      s_d.dataOk = 1'b0;
      s_d.idleSeen = 1'b0;
    end else begin
      if (rxPreamble) begin
        s_d.recover = 1'b1;
      end
      if (!rxPllLock) begin
        s_d.bitCnt = 2'h0;
      end else if (rxBitStrobe && s_q.bitCnt != 2'(`TLM_LOCK_BITS)) begin
        s_d.bitCnt = s_q.bitCnt + 2'h1;
      end
      if (s_q.bitCnt == 2'(`TLM_LOCK_BITS)) begin
        s_d.dataOk = 1'b1;
      end
      if (rxIdleMarker) begin
        s_d.idleSeen = 1'b1;
      end
    end

    unique case (s_q.state)
      TLM_INVALID: begin
        if (s_q.dataOk) begin
          s_d.state = TLM_WAIT_END;
          s_d.nlpCnt = 4'h0;
        end else if (rxNlp) begin
          if (s_q.nlpCnt == 4'(`TLM_NLP_NEED - 1)) begin
            s_d.state = TLM_VALID;
            s_d.nlpCnt = 4'h0;
          end else begin
            s_d.nlpCnt = s_q.nlpCnt + 4'h1;
          end
        end
      end
      TLM_WAIT_END: begin
        if (pktEnd) begin
          s_d.state = qualified ? TLM_VALID : TLM_INVALID;
        end
      end
      TLM_VALID: begin
        // a pulse or packet in the expiry cycle still keeps the link
        if (lossTick && !lossRestart) begin
          s_d.state = TLM_INVALID;
        end
      end
      default: begin
        s_d.state = TLM_INVALID;
        s_d.nlpCnt = 4'h0;
      end
    endcase

    // a drop in the read cycle still shows, since the reload uses the new state
    if (readLink) begin
      s_d.linkLatch = (s_d.state == TLM_VALID);
    end else begin
      s_d.linkLatch = s_q.linkLatch && (s_d.state == TLM_VALID);
    end

    if (setup) begin
      s_d.pslverr = !isMapped(paddr);
      s_d.prdata = `TLM_RST_WORD;
      if (!pwrite) begin
        case (paddr)
          `TLM_ADDR_CTRL: s_d.prdata[`TLM_CTRL_FDX] = s_q.fdx;
          `TLM_ADDR_BSTAT: s_d.prdata[`TLM_BSTAT_LINK] = s_q.linkLatch;
          `TLM_ADDR_DSTAT: s_d.prdata[`TLM_DSTAT_LINK] = s_q.linkLatch;
          `TLM_ADDR_OPS: s_d.prdata[`TLM_OPS_SQ_INH] = s_q.sqInh;
          default: s_d.prdata = `TLM_RST_WORD;
        endcase
      end
    end
    if (access && pwrite) begin
      if (paddr == `TLM_ADDR_CTRL) begin
        s_d.fdx = pwdata[`TLM_CTRL_FDX];
      end
      if (paddr == `TLM_ADDR_OPS) begin
        s_d.sqInh = pwdata[`TLM_OPS_SQ_INH];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.state <= TLM_INVALID;
      s_q.fdx <= `TLM_RST_FDX;
      s_q.sqInh <= `TLM_RST_SQ_INH;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign rxClkRecovered = s_q.recover;
  assign normalLinkPulse = nlpTick;
  assign txIdleMarker = s_q.idleMark;
  assign carrierSenseOut = s_q.carrier_sense_out;
  assign miiClk = s_q.miiClk;
  assign linkValid = (s_q.state == TLM_VALID);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_crs_half: assert property (!s_q.fdx && txEn |=> carrierSenseOut)
    else $error("carrier sense missing during half duplex transmit");
  chk_crs_full: assert property (s_q.fdx && txEn && !rxActive |=> !carrierSenseOut)
    else $error("carrier sense raised on transmit in full duplex");
  chk_idle_marker: assert property ($fell(txEn) |=> txIdleMarker)
    else $error("idle marker not sent after transmit");
  chk_nlp_valid: assert property (s_q.state == TLM_INVALID && !s_q.dataOk && rxNlp &&
      s_q.nlpCnt == 4'h7 |=> linkValid)
    else $error("eighth link pulse did not validate link");
  chk_latch_drop: assert property ($fell(linkValid) |-> !s_q.linkLatch)
    else $error("latched link bit stayed high after drop");
  chk_latch_noset: assert property (!s_q.linkLatch && !readLink |=> !s_q.linkLatch)
    else $error("latched link bit rose without a read");
  chk_read_reload: assert property (readLink |=> s_q.linkLatch == linkValid)
    else $error("read did not reload latched link bit");
  chk_mii_period: assert property ($rose(miiClk) |-> miiClk [*8] ##1 !miiClk)
    else $error("interface clock half period wrong");
  chk_wait_end: assert property (s_q.state == TLM_WAIT_END && rxActive |=> !linkValid)
    else $error("link validated before packet end");
  chk_lock_bits: assert property ($rose(s_q.dataOk) |-> $past(s_q.bitCnt) == 2'h3)
    else $error("data accepted with fewer than three locked bits");

  // receive clock, pulse generator and interface clock
  chk_rx_clock_on: assert property (
      rxActive && rxPreamble |=> rxClkRecovered)
    else $error("recovered clock not selected after preamble");
  chk_rx_clock_off: assert property (
      !rxActive |=> !rxClkRecovered)
    else $error("recovered clock kept after reception ended");
  chk_nlp_hold: assert property (
      txEn |=> !normalLinkPulse)
    else $error("link pulse sent during transmit");
  chk_nlp_single: assert property (
      normalLinkPulse |=> !normalLinkPulse)
    else $error("link pulse wider than one cycle");
  // pulse timer must not pause for reception
  chk_nlp_rx: assert property (
      rxActive && !txEn |=> u_nlp.s_q.cnt != $past(u_nlp.s_q.cnt))
    else $error("link pulse timer stalled during reception");
  chk_mii_low: assert property (
      $fell(miiClk) |-> !miiClk [*8] ##1 miiClk)
    else $error("interface clock low phase wrong");

  // link state machine
  chk_nlp_few: assert property (
      s_q.state == TLM_INVALID && !s_q.dataOk && s_q.nlpCnt != 4'h7 |=> !linkValid)
    else $error("link validated with too few pulses");
  chk_inh_data: assert property (
      s_q.state == TLM_WAIT_END && pktEnd && s_q.dataOk && s_q.sqInh |=> linkValid)
    else $error("valid data ignored with inhibit set");
  chk_need_idle: assert property (
      s_q.state == TLM_WAIT_END && pktEnd && !s_q.sqInh &&
      !s_q.idleSeen && !rxIdleMarker |=> !linkValid)
    else $error("packet without idle marker validated link");
  chk_idle_ok: assert property (
      s_q.state == TLM_WAIT_END && pktEnd && s_q.dataOk &&
      (s_q.idleSeen || rxIdleMarker) |=> linkValid)
    else $error("packet with idle marker did not validate link");
  chk_valid_keep: assert property (
      linkValid && (rxNlp || qualified) |=> linkValid)
    else $error("link dropped despite activity");
  chk_loss_drop: assert property (
      linkValid && lossTick && !rxNlp && !qualified |=> !linkValid)
    else $error("link kept after silence window");
  chk_loss_only: assert property (
      linkValid && !lossTick |=> linkValid)
    else $error("link dropped before silence window");
  chk_lock_reset: assert property (
      rxActive && !rxPllLock |=> s_q.bitCnt == 2'h0)
    else $error("locked bit count kept across lock loss");
  chk_wait_entry: assert property (
      s_q.state == TLM_INVALID && s_q.dataOk |=> s_q.state == TLM_WAIT_END)
    else $error("data on invalid link did not wait for packet end");

  // status reads, carrier sense and idle marker
  chk_bstat_read: assert property (
      setup && !pwrite && (paddr == `TLM_ADDR_BSTAT) |=>
      prdata[`TLM_BSTAT_LINK] == $past(s_q.linkLatch))
    else $error("basic status does not show latched link bit");
  chk_dstat_read: assert property (
      setup && !pwrite && (paddr == `TLM_ADDR_DSTAT) |=>
      prdata[`TLM_DSTAT_LINK] == $past(s_q.linkLatch))
    else $error("detailed status does not show latched link bit");
  chk_crs_rx_half: assert property (
      !s_q.fdx && rxActive |=> carrierSenseOut)
    else $error("carrier sense missing during half duplex receive");
  chk_crs_rx_full: assert property (
      s_q.fdx && rxActive |=> carrierSenseOut)
    else $error("carrier sense missing during full duplex receive");
  chk_no_marker: assert property (
      !$fell(txEn) |=> !txIdleMarker)
    else $error("idle marker sent without end of transmit");

  cov_nlp_valid: cover property (s_q.state == TLM_INVALID ##1 linkValid);
  cov_data_valid: cover property (s_q.state == TLM_WAIT_END ##1 linkValid);
  cov_link_loss: cover property (linkValid ##1 !linkValid);
  cov_nlp_rx: cover property (rxActive && normalLinkPulse);
  cov_inh_data: cover property (s_q.sqInh && s_q.state == TLM_WAIT_END ##1 linkValid);

endmodule : tlm_link_monitor

// file: tb/tlm_link_partner.sv
module tlm_link_partner (
  input wire logic clk, // system clock
  output logic rxActive, // energy on the pair
  output logic rxPreamble, // preamble seen
  output logic rxPllLock, // loop locked
  output logic rxBitStrobe, // bit time strobe
  output logic rxNlp, // link pulse seen
  output logic rxIdleMarker // idle marker seen
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {rxActive, rxPreamble, rxPllLock, rxBitStrobe, rxNlp, rxIdleMarker} = 6'h00;
  end
  // pulses spaced six cycles, well inside the loss window
  task automatic normal_link_pulse(input int n);
    repeat (n) begin
      @(posedge clk) rxNlp <= 1'b1;
      @(posedge clk) rxNlp <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : normal_link_pulse
  // six locked bits, so lock outlasts the three-bit minimum
  task automatic pkt(input logic mark);
    @(posedge clk) {rxActive, rxPreamble, rxPllLock} <= 3'h7;
    @(posedge clk) rxPreamble <= 1'b0;
    repeat (6) begin
      @(posedge clk) rxBitStrobe <= 1'b1;
      @(posedge clk) rxBitStrobe <= 1'b0;
    end
    @(posedge clk) rxIdleMarker <= mark;
    @(posedge clk) {rxActive, rxPllLock, rxIdleMarker} <= 3'h0;
  endtask : pkt
endmodule : tlm_link_partner

// file: tb/tenbase_t_link_monitor_tb_top.sv
`include "tlm_cfg.svh"
module tenbase_t_link_monitor_tb_top;
  import tlm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, txEn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, rxActive, rxPreamble, rxPllLock, rxBitStrobe, rxNlp;
  logic rxIdleMarker, rxClkRecovered, normalLinkPulse, txIdleMarker;
  logic carrierSenseOut, miiClk, linkValid, err;
  int num_errors = 0, total_checks = 0;

  tlm_link_monitor #(.NLP_CYCLES(40), .LOSS_CYCLES(200)) u_dut (.clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxActive,
    .rxPreamble, .rxPllLock, .rxBitStrobe, .rxNlp, .rxIdleMarker, .txEn,
    .rxClkRecovered, .normalLinkPulse, .txIdleMarker, .carrierSenseOut, .miiClk,
    .linkValid);
  tlm_link_partner u_lp (.clk, .rxActive, .rxPreamble, .rxPllLock, .rxBitStrobe,
    .rxNlp, .rxIdleMarker);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk(32'h1, 32'h0);
      wrap_up();
    end
  endtask : apb

  task automatic t_reset;
    apb(1'b0, `TLM_ADDR_BSTAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `TLM_ADDR_OPS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    chk({err, rd[30:0]}, 32'h8000_0000);
  endtask : t_reset

  task automatic t_pulses;
    u_lp.normal_link_pulse(7);
    chk(linkValid, 32'h0);
    u_lp.normal_link_pulse(1);
    chk(linkValid, 32'h1);
    apb(1'b0, `TLM_ADDR_BSTAT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `TLM_ADDR_DSTAT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, `TLM_ADDR_BSTAT, 32'h0);
    chk(rd, 32'h4);
    u_lp.normal_link_pulse(50);
    chk(linkValid, 32'h1);
    repeat (210) @(posedge clk);
    chk(linkValid, 32'h0);
    apb(1'b0, `TLM_ADDR_DSTAT, 32'h0);
    chk(rd, 32'h0);
  endtask : t_pulses

  task automatic t_data;
    u_lp.pkt(1'b0);
    repeat (2) @(posedge clk);
    chk(linkValid, 32'h0);
    fork
      u_lp.pkt(1'b1);
      begin
        // lands while the packet runs and the monitor already holds data
        repeat (12) @(posedge clk);
        chk({linkValid, rxClkRecovered, carrierSenseOut}, 32'h3);
      end
    join
    repeat (2) @(posedge clk);
    chk(linkValid, 32'h1);
    repeat (210) @(posedge clk);
    chk(linkValid, 32'h0);
    apb(1'b1, `TLM_ADDR_OPS, 32'h1);
    u_lp.pkt(1'b0);
    repeat (2) @(posedge clk);
    chk(linkValid, 32'h1);
  endtask : t_data

  task automatic t_tx;
    int np, mk, tg;
    logic last;
    {np, mk, tg} = '0;
    @(posedge clk) txEn <= 1'b1;
    // a pulse launched before the restart may still show at this edge
    @(posedge clk);
    repeat (60) begin
      @(posedge clk);
      np += normalLinkPulse;
    end
    chk({np[30:0], carrierSenseOut}, 32'h1);
    txEn <= 1'b0;
    last = miiClk;
    for (int i = 0; i < 176; i++) begin
      @(posedge clk);
      if (i < 4)
        mk += txIdleMarker;
      np += normalLinkPulse;
      tg += (miiClk != last);
      last = miiClk;
    end
    chk(32'(mk), 32'h1);
    chk(32'(np), 32'h4);
    chk(32'(tg), 32'h16);
    apb(1'b1, `TLM_ADDR_CTRL, 32'h100);
    txEn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(carrierSenseOut, 32'h0);
    txEn <= 1'b0;
  endtask : t_tx

  initial begin
    rst <= 1'b1;
    {psel, penable, pwrite, txEn} <= 4'h0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pulses();
    t_data();
    t_tx();
    wrap_up();
  end
endmodule : tenbase_t_link_monitor_tb_top
